// ### fpm_profile_map.sv
// Profile selection and one-bit object mapping between fieldbus record jobs
// and the building-bus object side.
// Assumes one-cycle job requests from a record-job front end and a bus sender
// that accepts one object per valid/ready handshake.
//
// Behaviour
// - At most 240 objects are supported and no area exceeds 211 bytes per direction.
// - Each data area has a value section and a control section of event or repeat bits.
// - The data record number in each read or write job is taken as the profile selector.
// - The first record job naming record 2 to 6 after activation fixes the active profile.
// - The fixed profile holds until the link is lost; a new one is fixed only after the master activates again.
// - Records 2 to 6 select the 240, 178, 118, 60 and 32 object profiles.
// - One-bit capacity is 128, 96, 64, 32 and 16 objects in those profiles.
// - Object numbers are fixed per data type, one-bit objects starting at zero.
// - One-bit object n sits in byte n/8 at bit n mod 8 in every profile.
// - Objects beyond the active profile capacity are not mapped and not reachable.
// - Received data and finished sends raise event bits; changes or repeat bits send.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_defs.svh"

module fpm_profile_map import fpm_pkg::*; #(
  parameter int NOBJ = 128
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Fieldbus link state
  input wire logic activate_in,
  input wire logic link_lost_in,
  // Record job request and answer
  input wire logic job_valid_in,
  input wire logic job_write_in,
  input wire logic [7:0] job_index_in,
  input wire logic [7:0] job_addr_in,
  input wire logic [7:0] job_wdata_in,
  output logic job_done_out,
  output logic job_err_out,
  output logic [7:0] job_rdata_out,
  // Profile status
  output logic locked_out,
  output logic [7:0] prof_cap_out,
  // Building-bus receive side
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_num_in,
  input wire logic rx_val_in,
  // Building-bus send side
  output logic tx_valid_out,
  output logic [7:0] tx_num_out,
  output logic tx_val_out,
  input wire logic tx_ready_in
);

  localparam int NB = NOBJ / 8;
  localparam int BW = $clog2(NB);
  localparam int OW = $clog2(NOBJ);

  fpm_state_e state_q;
  fpm_prof_e prof_q;
  fpm_prof_e job_prof;
  fpm_prof_e eff_prof;
  logic [7:0] cap_bits;
  logic [7:0] cap_now;
  logic is_ctl;
  logic [7:0] byte_idx;
  logic [BW-1:0] bsel;
  logic prof_ok;
  logic job_ok;
  logic lock_now;
  logic rx_ok;
  logic [7:0] rd_val;
  logic [NOBJ-1:0] in_set, out_we, ev_set, ev_clr, pend_set, pend_clr;
  logic [NOBJ-1:0] in_bits, out_bits, ev_bits, pend_bits;
  logic pick_any;
  logic [OW-1:0] pick_idx;

  // Record number decode; anything outside 2..6 names no profile.
  function automatic fpm_prof_e dec_rec(input logic [7:0] rec);
    case (rec)
      `FPM_REC_240: dec_rec = FPM_P240;
      `FPM_REC_178: dec_rec = FPM_P178;
      `FPM_REC_118: dec_rec = FPM_P118;
      `FPM_REC_60: dec_rec = FPM_P60;
      `FPM_REC_32: dec_rec = FPM_P32;
      default: dec_rec = FPM_PNONE;
    endcase
  endfunction

  // One-bit capacity per profile; zero when no profile is known.
  function automatic logic [7:0] cap_of(input fpm_prof_e p);
    case (p)
      FPM_P240: cap_of = `FPM_CAP_240;
      FPM_P178: cap_of = `FPM_CAP_178;
      FPM_P118: cap_of = `FPM_CAP_118;
      FPM_P60: cap_of = `FPM_CAP_60;
      FPM_P32: cap_of = `FPM_CAP_32;
      default: cap_of = 8'h00;
    endcase
  endfunction

  // Job qualification: the open state takes its profile from the job itself.
  assign job_prof = dec_rec(job_index_in);
  assign eff_prof = (state_q == FPM_ST_OPEN) ? job_prof : prof_q;
  assign cap_bits = cap_of(eff_prof);
  assign cap_now = cap_of(prof_q);
  assign is_ctl = (job_addr_in >= `FPM_CTRL_BASE);
  assign byte_idx = is_ctl ? job_addr_in - `FPM_CTRL_BASE : job_addr_in;
  assign bsel = byte_idx[BW-1:0];
  assign prof_ok = (state_q == FPM_ST_OPEN) ? (job_prof != FPM_PNONE)
                 : (state_q == FPM_ST_LOCKED) && (job_prof == prof_q);
  assign job_ok = job_valid_in && prof_ok && (byte_idx < {3'h0, cap_bits[7:3]});
  assign lock_now = job_valid_in && (state_q == FPM_ST_OPEN) && (job_prof != FPM_PNONE);
  assign rd_val = is_ctl ? ev_bits[bsel*8 +: 8] : in_bits[bsel*8 +: 8];
  assign rx_ok = rx_valid_in && (state_q == FPM_ST_LOCKED) && (rx_num_in < cap_now);

  // Link state: a loss always wins, so a stale lock never survives it.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= FPM_ST_IDLE;
    end else if (link_lost_in) begin
      state_q <= FPM_ST_IDLE;
    end else if (state_q == FPM_ST_IDLE && activate_in) begin
      state_q <= FPM_ST_OPEN;
    end else if (lock_now) begin
      state_q <= FPM_ST_LOCKED;
    end
  end

  // Profile register, loaded only on the locking job and cleared on a link loss.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prof_q <= FPM_PNONE;
    end else if (link_lost_in) begin
      prof_q <= FPM_PNONE;
    end else if (lock_now) begin
      prof_q <= job_prof;
    end
  end

  assign locked_out = (state_q == FPM_ST_LOCKED);
  assign prof_cap_out = cap_now;

  // Job answer one cycle after the request; refused jobs read back zero.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      job_done_out <= 1'b0;
      job_err_out <= 1'b0;
      job_rdata_out <= 8'h00;
    end else begin
      job_done_out <= job_valid_in;
      job_err_out <= job_valid_in && !job_ok;
      job_rdata_out <= (job_ok && !job_write_in) ? rd_val : 8'h00;
    end
  end

  // Strobes into the cells. Only qualified jobs touch storage.
  always_comb begin
    out_we = '0;
    pend_set = '0;
    ev_clr = '0;
    in_set = '0;
    if (job_ok && job_write_in && !is_ctl) begin
      out_we[bsel*8 +: 8] = 8'hff;
      pend_set[bsel*8 +: 8] = job_wdata_in ^ out_bits[bsel*8 +: 8];
    end
    if (job_ok && job_write_in && is_ctl) begin
      pend_set[bsel*8 +: 8] = job_wdata_in;
    end
    if (job_ok && !job_write_in && is_ctl) begin
      ev_clr[bsel*8 +: 8] = 8'hff;
    end
    if (rx_ok) begin
      in_set[rx_num_in[OW-1:0]] = 1'b1;
    end
  end

  // Events come from received data and from sends the bus has taken.
  always_comb begin
    ev_set = in_set;
    if (tx_valid_out && tx_ready_in) begin
      ev_set[tx_num_out[OW-1:0]] = 1'b1;
    end
  end

  // Lowest pending object goes out first; a simple fixed priority is used, so
  // a master that keeps raising a lower object's pending bit can starve the higher ones.
  // Objects beyond the locked capacity stay pending but are never sent.
  always_comb begin
    pick_any = 1'b0;
    pick_idx = '0;
    for (int k = NOBJ - 1; k >= 0; k--) begin
      if (pend_bits[k] && (k < int'(cap_now))) begin
        pick_any = 1'b1;
        pick_idx = OW'(k);
      end
    end
  end

  assign pend_clr = (pick_any && !link_lost_in && (!tx_valid_out || tx_ready_in))
                  ? (NOBJ'(1) << pick_idx) : '0;

  // Send register holds until the bus side accepts it; a link loss drops it,
  // because the object may not exist in the profile chosen next.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_valid_out <= 1'b0;
      tx_num_out <= 8'h00;
      tx_val_out <= 1'b0;
    end else if (link_lost_in) begin
      tx_valid_out <= 1'b0;
    end else if (!tx_valid_out || tx_ready_in) begin
      tx_valid_out <= pick_any;
      tx_num_out <= `FPM_BIT_FIRST_OBJ + 8'(pick_idx);
      tx_val_out <= out_bits[pick_idx];
    end
  end

  // One-bit object storage, sized for the largest profile.
  fpm_obj_cells #(.NOBJ(NOBJ)) u_cells (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .in_set_in(in_set),
    .in_val_in(rx_val_in),
    .out_we_in(out_we),
    .out_data_in({NB{job_wdata_in}}),
    .ev_set_in(ev_set),
    .ev_clr_in(ev_clr),
    .pend_set_in(pend_set),
    .pend_clr_in(pend_clr),
    .in_bits_out(in_bits),
    .out_bits_out(out_bits),
    .ev_bits_out(ev_bits),
    .pend_bits_out(pend_bits)
  );

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  a_job_answered: assert property (job_valid_in |=> job_done_out)
    else $error("job not answered next cycle");
  a_first_job_locks: assert property (
    lock_now && !link_lost_in |=> locked_out && prof_q == $past(job_prof))
    else $error("first job did not lock profile");
  a_profile_held: assert property (locked_out && !link_lost_in |=> $stable(prof_q))
    else $error("locked profile changed");
  a_rec2_capacity: assert property (locked_out && prof_q == FPM_P240 |-> prof_cap_out == 8'd128)
    else $error("record 2 capacity wrong");
  a_other_rec_refused: assert property (
    locked_out && job_valid_in && job_prof != prof_q |=> job_err_out && $stable(out_bits))
    else $error("foreign record not refused");
  a_read_bit_place: assert property (
    job_ok && !job_write_in && !is_ctl |=> job_rdata_out == $past(rd_val))
    else $error("read byte misplaced");
  a_send_in_range: assert property (tx_valid_out |-> tx_num_out < cap_now)
    else $error("send beyond capacity");
  a_ctl_keeps_values: assert property (
    job_valid_in && job_write_in && is_ctl |=> $stable(out_bits))
    else $error("control write changed values");
  a_rx_raises_event: assert property (
    rx_ok |=> ev_bits[$past(rx_num_in[OW-1:0])]
      && (in_bits[$past(rx_num_in[OW-1:0])] == $past(rx_val_in)))
    else $error("reception raised no event");

  c_lock: cover property (lock_now);
  c_refused: cover property (locked_out && job_valid_in && !job_ok);
  c_send_done: cover property (tx_valid_out && tx_ready_in);

endmodule

`default_nettype wire

// ### fpm_defs.svh
// Constants for the fieldbus object profile map: record numbers, capacities, layout.
// Assumes inclusion by bare name from the design files of this block.
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH

// Total object budget and largest data area in bytes per direction.
`define FPM_MAX_OBJECTS 8'd240
`define FPM_MAX_AREA_BYTES 8'd211

// Data record numbers that select a profile.
`define FPM_REC_240 8'h02
`define FPM_REC_178 8'h03
`define FPM_REC_118 8'h04
`define FPM_REC_60 8'h05
`define FPM_REC_32 8'h06

// One-bit object capacity of each profile.
`define FPM_CAP_240 8'd128
`define FPM_CAP_178 8'd96
`define FPM_CAP_118 8'd64
`define FPM_CAP_60 8'd32
`define FPM_CAP_32 8'd16

// First object number of the one-bit type area.
`define FPM_BIT_FIRST_OBJ 8'd0

// Job byte address where the control section (event or repeat bits) begins.
`define FPM_CTRL_BASE 8'h80

`endif

// ### fpm_pkg.sv
// Types shared by the fieldbus object profile map.
// Assumes nothing of its surroundings.
package fpm_pkg;

  // Link state towards the fieldbus master.
  typedef enum logic [1:0] {
    FPM_ST_IDLE,
    FPM_ST_OPEN,
    FPM_ST_LOCKED
  } fpm_state_e;

  // Profile selected by the data record number.
  typedef enum logic [2:0] {
    FPM_P240,
    FPM_P178,
    FPM_P118,
    FPM_P60,
    FPM_P32,
    FPM_PNONE
  } fpm_prof_e;

endpackage

// ### fpm_obj_cells.sv
// Per-object storage cells: input value, output value, event bit, send request.
// Assumes the caller provides one-hot or masked strobes per object.
`timescale 1ns/1ps
`default_nettype none

module fpm_obj_cells #(
  parameter int NOBJ = 128
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Strobes and data
  input wire logic [NOBJ-1:0] in_set_in,
  input wire logic in_val_in,
  input wire logic [NOBJ-1:0] out_we_in,
  input wire logic [NOBJ-1:0] out_data_in,
  input wire logic [NOBJ-1:0] ev_set_in,
  input wire logic [NOBJ-1:0] ev_clr_in,
  input wire logic [NOBJ-1:0] pend_set_in,
  input wire logic [NOBJ-1:0] pend_clr_in,
  // Stored state
  output logic [NOBJ-1:0] in_bits_out,
  output logic [NOBJ-1:0] out_bits_out,
  output logic [NOBJ-1:0] ev_bits_out,
  output logic [NOBJ-1:0] pend_bits_out
);

  genvar i;
  generate
    for (i = 0; i < NOBJ; i++) begin : g_cell
      // Object values in both directions.
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          in_bits_out[i] <= 1'b0;
          out_bits_out[i] <= 1'b0;
        end else begin
          if (in_set_in[i]) begin
            in_bits_out[i] <= in_val_in;
          end
          if (out_we_in[i]) begin
            out_bits_out[i] <= out_data_in[i];
          end
        end
      end

      // Flags: a set arriving with a clear wins so no event is lost.
      always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
          ev_bits_out[i] <= 1'b0;
          pend_bits_out[i] <= 1'b0;
        end else begin
          if (ev_set_in[i]) begin
            ev_bits_out[i] <= 1'b1;
          end else if (ev_clr_in[i]) begin
            ev_bits_out[i] <= 1'b0;
          end
          if (pend_set_in[i]) begin
            pend_bits_out[i] <= 1'b1;
          end else if (pend_clr_in[i]) begin
            pend_bits_out[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ### fpm_bus_sink.sv
// Building-bus sender model that accepts send requests from the profile map.
// Assumes valid is held until accepted; slow mode stalls all but one cycle in four.
`timescale 1ns/1ps
`default_nettype none

module fpm_bus_sink (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Handshake
  input wire logic valid_in,
  input wire logic slow_in,
  output logic ready_out
);
  logic [1:0] phase_q;

  // Free-running phase so that a slow bus stalls the sender for several cycles.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Ready only while a request stands, so a stray ready cannot hide a late valid.
  assign ready_out = valid_in && (!slow_in || (phase_q == 2'h3));
endmodule

`default_nettype wire

// ### fpm_profile_map_tb.sv
// Testbench for the fieldbus object profile map: profile walk, reception, send path.
// Assumes the map and the bus sink model compile alongside this file.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_defs.svh"

module fpm_profile_map_tb import fpm_pkg::*;;
  logic sys_clk, reset, act, lost, jv, jw, done, err, locked, rxv, rxval, txv, txval, txr, slow;
  logic [7:0] jidx, jaddr, jwd, rdata, cap, rxn, txn;
  logic [127:0] in_m, ev_m;
  logic [8:0] acc_q[$];
  int n_mismatch, check_count, seed, k, b;

  fpm_profile_map #(.NOBJ(128)) uut (.sys_clk_in(sys_clk), .reset_in(reset),
    .activate_in(act), .link_lost_in(lost), .job_valid_in(jv), .job_write_in(jw),
    .job_index_in(jidx), .job_addr_in(jaddr), .job_wdata_in(jwd), .job_done_out(done),
    .job_err_out(err), .job_rdata_out(rdata), .locked_out(locked), .prof_cap_out(cap),
    .rx_valid_in(rxv), .rx_num_in(rxn), .rx_val_in(rxval), .tx_valid_out(txv),
    .tx_num_out(txn), .tx_val_out(txval), .tx_ready_in(txr));
  fpm_bus_sink sink (.sys_clk_in(sys_clk), .reset_in(reset), .valid_in(txv),
    .slow_in(slow), .ready_out(txr));

  // Clock at 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Every accepted send is logged as {value, object number}.
  always @(posedge sys_clk) begin
    if (txv && txr) begin
      acc_q.push_back({txval, txn});
    end
  end

  // Capacity expected for each profile position, record number minus two.
  function automatic logic [7:0] cap_of(input int p);
    case (p)
      0: cap_of = `FPM_CAP_240;
      1: cap_of = `FPM_CAP_178;
      2: cap_of = `FPM_CAP_118;
      3: cap_of = `FPM_CAP_60;
      default: cap_of = `FPM_CAP_32;
    endcase
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One record job; the answer stands in the cycle after the taking edge.
  task automatic job(input logic w, input logic [7:0] idx, input logic [7:0] a,
                     input logic [7:0] d, input logic e, input logic [7:0] r);
    jv = 1'b1;
    jw = w;
    jidx = idx;
    jaddr = a;
    jwd = d;
    @(negedge sys_clk);
    jv = 1'b0;
    chk({7'h0, done}, 8'h01);
    chk({7'h0, err}, {7'h0, e});
    chk(rdata, r);
    // One idle cycle so that a following job never re-raises the strobe in this step.
    @(negedge sys_clk);
  endtask

  task automatic rx(input logic [7:0] n, input logic v, input logic take);
    rxv = 1'b1;
    rxn = n;
    rxval = v;
    @(negedge sys_clk);
    rxv = 1'b0;
    if (take) begin
      in_m[n[6:0]] = v;
      ev_m[n[6:0]] = 1'b1;
    end
    @(negedge sys_clk);
  endtask

  // Drop the link, reactivate and lock profile p with a value read of byte 0.
  task automatic lock(input int p);
    lost = 1'b1;
    @(negedge sys_clk);
    lost = 1'b0;
    act = 1'b1;
    @(negedge sys_clk);
    act = 1'b0;
    job(1'b0, 8'h02 + p[7:0], 8'h00, 8'h00, 1'b0, in_m[7:0]);
    chk({7'h0, locked}, 8'h01);
    chk(cap, cap_of(p));
  endtask

  task automatic wait_acc(input int n);
    for (int i = 0; i < 200 && acc_q.size() < n; i++) begin
      @(negedge sys_clk);
    end
    if (acc_q.size() < n) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, acc_q.size(), n);
      report_and_stop();
    end
  endtask

  task automatic chk_acc(input int i, input logic [8:0] e);
    chk(acc_q[i][7:0], e[7:0]);
    chk({7'h0, acc_q[i][8]}, {7'h0, e[8]});
  endtask

  // Main sequence.
  initial begin
    {reset, act, lost, jv, jw, rxv, rxval, slow} = 8'h80;
    {jidx, jaddr, jwd, rxn} = 32'h0;
    in_m = '0;
    ev_m = '0;
    n_mismatch = 0;
    check_count = 0;
    seed = 11884;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    job(1'b0, 8'h02, 8'h00, 8'h00, 1'b1, 8'h00);
    act = 1'b1;
    @(negedge sys_clk);
    act = 1'b0;
    job(1'b0, 8'h07, 8'h00, 8'h00, 1'b1, 8'h00);
    chk({7'h0, locked}, 8'h00);
    // Walk every profile: edge bytes of both sections and a foreign record.
    for (int p = 0; p < 5; p++) begin
      lock(p);
      b = cap_of(p) / 8;
      job(1'b0, 8'h02 + p[7:0], b[7:0] - 8'h01, 8'h00, 1'b0, 8'h00);
      job(1'b0, 8'h02 + p[7:0], b[7:0], 8'h00, 1'b1, 8'h00);
      job(1'b0, 8'h02 + p[7:0], 8'h80 + b[7:0], 8'h00, 1'b1, 8'h00);
      job(1'b1, 8'h02 + ((p[7:0] + 8'h01) % 8'h05), 8'h00, 8'hff, 1'b1, 8'h00);
      chk(cap, cap_of(p));
    end
    chk(8'(acc_q.size()), 8'h00);
    // Random reception, then every value byte and event byte read back.
    lock(0);
    repeat (40) begin
      k = $random(seed);
      rx({1'b0, k[6:0]}, k[9], 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      job(1'b0, 8'h02, i[7:0], 8'h00, 1'b0, in_m[i*8 +: 8]);
      job(1'b0, 8'h02, 8'h80 + i[7:0], 8'h00, 1'b0, ev_m[i*8 +: 8]);
    end
    ev_m = '0;
    job(1'b0, 8'h02, 8'h80, 8'h00, 1'b0, 8'h00);
    // Object 20 is beyond the smallest profile and must be ignored there.
    lock(4);
    rx(8'd20, ~in_m[20], 1'b0);
    rx(8'd5, ~in_m[5], 1'b1);
    lock(0);
    job(1'b0, 8'h02, 8'h02, 8'h00, 1'b0, in_m[23:16]);
    job(1'b0, 8'h02, 8'h80, 8'h00, 1'b0, ev_m[7:0]);
    // Value change on objects 0 and 2 with a stalling bus, lowest first.
    slow = 1'b1;
    job(1'b1, 8'h02, 8'h00, 8'h05, 1'b0, 8'h00);
    wait_acc(2);
    @(negedge sys_clk);
    chk_acc(0, 9'h100);
    chk_acc(1, 9'h102);
    job(1'b0, 8'h02, 8'h80, 8'h00, 1'b0, 8'h05);
    // Repeat bit of object 15 resends its unchanged output value.
    slow = 1'b0;
    job(1'b1, 8'h02, 8'h81, 8'h80, 1'b0, 8'h00);
    wait_acc(3);
    chk_acc(2, 9'h00f);
    report_and_stop();
  end
endmodule

`default_nettype wire
